// [design/sic_pkg.sv]
package sic_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADR_PORT0      = 8'h80;
    localparam logic [7:0] ADR_STACK      = 8'h81;
    localparam logic [7:0] ADR_DPTR_LO    = 8'h82;
    localparam logic [7:0] ADR_DPTR_HI    = 8'h83;
    localparam logic [7:0] ADR_LINE_EN    = 8'h84;
    localparam logic [7:0] ADR_LINE_FLAGS = 8'h85;
    localparam logic [7:0] ADR_PWM_FLAGS  = 8'h86;
    localparam logic [7:0] ADR_POWER_CTRL = 8'h87;
    localparam logic [7:0] ADR_TMR_CTRL   = 8'h88;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_STACK = 8'h07;
    localparam logic [7:0] RST_ZERO  = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int PWR_DOUBLE_BIT = 7;
    localparam int PWR_FLAG_B_BIT = 3;
    localparam int PWR_FLAG_A_BIT = 2;
    localparam int PWR_DOWN_BIT   = 1;
    localparam int PWR_SLEEP_BIT  = 0;
    localparam int TC_T1_OVF_BIT  = 7;
    localparam int TC_T1_RUN_BIT  = 6;
    localparam int TC_T0_OVF_BIT  = 5;
    localparam int TC_T0_RUN_BIT  = 4;
    localparam int TC_X1_FLAG_BIT = 3;
    localparam int TC_X1_SEL_BIT  = 2;
    localparam int TC_X0_FLAG_BIT = 1;
    localparam int TC_X0_SEL_BIT  = 0;
    localparam int LINE_COUNT     = 8;
    localparam int PWM_COUNT      = 3;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sic_sfr_req_t;

    typedef struct packed {
        logic t1_ovf;
        logic t0_ovf;
        logic t1_ack;
        logic t0_ack;
        logic x1_ack;
        logic x0_ack;
    } sic_tmr_evt_t;

endpackage : sic_pkg

// [design/sic_pin_sync.sv]
`timescale 1ns/1ps
module sic_pin_sync #(
    parameter int WIDTH = 10
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out,
    output logic      [WIDTH-1:0] fall_out
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] next_level;

    // A change counts only once the last two stages agree
    assign next_level = (~(s2 ^ s3) & s3) | ((s2 ^ s3) & level_out);

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            s1        <= '1;
            s2        <= '1;
            s3        <= '1;
            level_out <= '1;
            fall_out  <= '0;
        end else if (ce_in) begin
            s1        <= pin_in;
            s2        <= s1;
            s3        <= s2;
            level_out <= next_level;
            fall_out  <= level_out & ~next_level;
        end
    end
endmodule : sic_pin_sync

// [design/sic_flag_bank.sv]
`timescale 1ns/1ps
module sic_flag_bank #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_sys_in,
    input  wire logic             rst_n_in,
    input  wire logic             ce_in,
    input  wire logic [WIDTH-1:0] set_in,
    input  wire logic [WIDTH-1:0] clr_in,
    output logic      [WIDTH-1:0] flag_out
);
    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            flag_out <= '0;
        end else if (ce_in) begin
            flag_out <= (flag_out & ~clr_in) | set_in;
        end
    end
endmodule : sic_flag_bank

// [design/sic_sfr_irq_top.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module sic_sfr_irq_top
    import sic_pkg::*;
(
    input  wire logic         clk_sys_in,
    input  wire logic         rst_n_in,
    input  wire logic         ce_in,
    input  wire sic_sfr_req_t sfr_req_in,
    input  wire logic [7:0]   ext_line_pins_in,
    input  wire logic         ext_line0_pin_in,
    input  wire logic         ext_line1_pin_in,
    input  wire logic [2:0]   pwm_event_in,
    input  wire sic_tmr_evt_t tmr_evt_in,
    input  wire logic         global_irq_enable_in,
    input  wire logic         low_voltage_detect_irq_enable_in,
    input  wire logic         timer1_pin_gating_in,
    output logic      [7:0]   sfr_rdata_out,
    output logic              sfr_hit_out,
    output logic      [7:0]   port0_data_out,
    output logic      [7:0]   stack_pointer_out,
    output logic      [15:0]  data_pointer_out,
    output logic      [7:0]   ext_line_irq_out,
    output logic      [2:0]   pwm_irq_out,
    output logic              ext0_irq_out,
    output logic              ext1_irq_out,
    output logic              timer0_irq_out,
    output logic              timer1_irq_out,
    output logic              timer0_count_en_out,
    output logic              timer1_count_en_out,
    output logic              uart1_double_rate_out,
    output logic              idle_out,
    output logic              power_down_out,
    output logic              wake_out
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic logic sfr_sel(input sic_sfr_req_t r, input logic [7:0] a);
        return r.addr == a;
    endfunction : sfr_sel

    logic [7:0] wd;
    logic       wr_p0;
    logic       wr_sp;
    logic       wr_dl;
    logic       wr_dh;
    logic       wr_en;
    logic       wr_lf;
    logic       wr_pf;
    logic       wr_pc;
    logic       wr_tc;

    assign wd    = sfr_req_in.wdata;
    assign wr_p0 = sfr_req_in.wr && sfr_sel(sfr_req_in, ADR_PORT0);
    assign wr_sp = sfr_req_in.wr && sfr_sel(sfr_req_in, ADR_STACK);
    assign wr_dl = sfr_req_in.wr && sfr_sel(sfr_req_in, ADR_DPTR_LO);
    assign wr_dh = sfr_req_in.wr && sfr_sel(sfr_req_in, ADR_DPTR_HI);
    assign wr_en = sfr_req_in.wr && sfr_sel(sfr_req_in, ADR_LINE_EN);
    assign wr_lf = sfr_req_in.wr && sfr_sel(sfr_req_in, ADR_LINE_FLAGS);
    assign wr_pf = sfr_req_in.wr && sfr_sel(sfr_req_in, ADR_PWM_FLAGS);
    assign wr_pc = sfr_req_in.wr && sfr_sel(sfr_req_in, ADR_POWER_CTRL);
    assign wr_tc = sfr_req_in.wr && sfr_sel(sfr_req_in, ADR_TMR_CTRL);

    // ------------------------------------------------------------
    // Storage registers
    // ------------------------------------------------------------
    logic [7:0] port0;
    logic [7:0] stack_ptr;
    logic [7:0] dptr_lo;
    logic [7:0] dptr_hi;
    logic [7:0] line_en;
    logic       dbl_rate;
    logic       flag_b;
    logic       flag_a;
    logic       pd;
    logic       sleep_light_request;
    logic       tr1;
    logic       tr0;
    logic       it1;
    logic       it0;

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            port0     <= RST_ZERO;
            stack_ptr <= RST_STACK;
            dptr_lo   <= RST_ZERO;
            dptr_hi   <= RST_ZERO;
            line_en   <= RST_ZERO;
        end else if (ce_in) begin
            if (wr_p0) port0 <= wd;
            if (wr_sp) stack_ptr <= wd;
            if (wr_dl) dptr_lo <= wd;
            if (wr_dh) dptr_hi <= wd;
            if (wr_en) line_en <= wd;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            dbl_rate <= 1'b0;
            flag_b   <= 1'b0;
            flag_a   <= 1'b0;
        end else if (ce_in && wr_pc) begin
            dbl_rate <= wd[PWR_DOUBLE_BIT];
            flag_b   <= wd[PWR_FLAG_B_BIT];
            flag_a   <= wd[PWR_FLAG_A_BIT];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tr1 <= 1'b0;
            tr0 <= 1'b0;
            it1 <= 1'b0;
            it0 <= 1'b0;
        end else if (ce_in && wr_tc) begin
            tr1 <= wd[TC_T1_RUN_BIT];
            tr0 <= wd[TC_T0_RUN_BIT];
            it1 <= wd[TC_X1_SEL_BIT];
            it0 <= wd[TC_X0_SEL_BIT];
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers and event flags
    // ------------------------------------------------------------
    logic [9:0] pin_lvl;
    logic [9:0] pin_fall;
    logic [7:0] line_fall;
    logic [7:0] line_flags;
    logic [2:0] pwm_flags;
    logic [3:0] tc_flags;
    logic [3:0] tc_wr_bits;
    logic [3:0] tc_set;
    logic [3:0] tc_clr;

    sic_pin_sync #(.WIDTH(10)) u_pin_sync (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .pin_in     ({ext_line1_pin_in, ext_line0_pin_in, ext_line_pins_in}),
        .level_out  (pin_lvl),
        .fall_out   (pin_fall)
    );

    assign line_fall = pin_fall[7:0];

    // Writing 1 to a pending flag leaves it alone
    sic_flag_bank #(.WIDTH(LINE_COUNT)) u_line_flags (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .set_in     (line_fall),
        .clr_in     (wr_lf ? ~wd : 8'h00),
        .flag_out   (line_flags)
    );

    sic_flag_bank #(.WIDTH(PWM_COUNT)) u_pwm_flags (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .set_in     (pwm_event_in),
        .clr_in     (wr_pf ? ~wd[2:0] : 3'h0),
        .flag_out   (pwm_flags)
    );

    // Order inside the bank: timer 1, timer 0, line 1, line 0
    assign tc_wr_bits = {wd[TC_T1_OVF_BIT], wd[TC_T0_OVF_BIT],
                         wd[TC_X1_FLAG_BIT], wd[TC_X0_FLAG_BIT]};
    assign tc_set = {tmr_evt_in.t1_ovf, tmr_evt_in.t0_ovf,
                     pin_fall[9] & it1, pin_fall[8] & it0}
                  | (wr_tc ? tc_wr_bits : 4'h0);
    assign tc_clr = {tmr_evt_in.t1_ack, tmr_evt_in.t0_ack,
                     tmr_evt_in.x1_ack, tmr_evt_in.x0_ack}
                  | (wr_tc ? ~tc_wr_bits : 4'h0);

    sic_flag_bank #(.WIDTH(4)) u_tc_flags (
        .clk_sys_in (clk_sys_in),
        .rst_n_in   (rst_n_in),
        .ce_in      (ce_in),
        .set_in     (tc_set),
        .clr_in     (tc_clr),
        .flag_out   (tc_flags)
    );

    // ------------------------------------------------------------
    // Requests, wake and power modes
    // ------------------------------------------------------------
    logic [7:0] line_req;
    logic       ext0_req;
    logic       ext1_req;
    logic       any_req;
    logic       wake;
    logic       next_pd;
    logic       next_idl;
    logic       next_t1_cnt;

    assign line_req = line_flags & line_en
                    & {8{low_voltage_detect_irq_enable_in}};
    // Level mode is not latched: a short low pulse is missed by design
    assign ext0_req = it0 ? tc_flags[0] : ~pin_lvl[8];
    assign ext1_req = it1 ? tc_flags[1] : ~pin_lvl[9];
    assign any_req  = (|line_req) | (|pwm_flags) | tc_flags[3] | tc_flags[2]
                    | ext0_req | ext1_req;
    // Global enable deliberately absent from wake
    assign wake     = pd & (|line_req);
    // A write of 1 wins over a wake arriving in the same cycle
    assign next_pd  = (wr_pc & wd[PWR_DOWN_BIT])
                    | (pd & ~wr_pc & ~wake);
    assign next_idl = (wr_pc & wd[PWR_SLEEP_BIT])
                    | (sleep_light_request & ~wr_pc & ~wake & ~(global_irq_enable_in & any_req));
    assign next_t1_cnt = tr1 & (~timer1_pin_gating_in | pin_lvl[9]);

    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            pd  <= 1'b0;
            sleep_light_request <= 1'b0;
        end else if (ce_in) begin
            pd  <= next_pd;
            sleep_light_request <= next_idl;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ext_line_irq_out    <= 8'h00;
            pwm_irq_out         <= 3'h0;
            ext0_irq_out        <= 1'b0;
            ext1_irq_out        <= 1'b0;
            timer0_irq_out      <= 1'b0;
            timer1_irq_out      <= 1'b0;
            timer0_count_en_out <= 1'b0;
            timer1_count_en_out <= 1'b0;
            wake_out            <= 1'b0;
        end else if (ce_in) begin
            ext_line_irq_out    <= line_req;
            pwm_irq_out         <= pwm_flags;
            ext0_irq_out        <= ext0_req;
            ext1_irq_out        <= ext1_req;
            timer0_irq_out      <= tc_flags[2];
            timer1_irq_out      <= tc_flags[3];
            timer0_count_en_out <= tr0;
            timer1_count_en_out <= next_t1_cnt;
            wake_out            <= wake;
        end
    end

    assign port0_data_out        = port0;
    assign stack_pointer_out     = stack_ptr;
    assign data_pointer_out      = {dptr_hi, dptr_lo};
    assign uart1_double_rate_out = dbl_rate;
    assign idle_out              = sleep_light_request;
    assign power_down_out        = pd;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    logic       rd_map;

    always_comb begin
        rd_map = 1'b1;
        if (sfr_sel(sfr_req_in, ADR_PORT0)) rd_mux = port0;
        else if (sfr_sel(sfr_req_in, ADR_STACK)) rd_mux = stack_ptr;
        else if (sfr_sel(sfr_req_in, ADR_DPTR_LO)) rd_mux = dptr_lo;
        else if (sfr_sel(sfr_req_in, ADR_DPTR_HI)) rd_mux = dptr_hi;
        else if (sfr_sel(sfr_req_in, ADR_LINE_EN)) rd_mux = line_en;
        else if (sfr_sel(sfr_req_in, ADR_LINE_FLAGS)) rd_mux = line_flags;
        else if (sfr_sel(sfr_req_in, ADR_PWM_FLAGS)) rd_mux = {5'h00, pwm_flags};
        else if (sfr_sel(sfr_req_in, ADR_POWER_CTRL)) begin
            rd_mux = {dbl_rate, 3'h0, flag_b, flag_a, pd, sleep_light_request};
        end else if (sfr_sel(sfr_req_in, ADR_TMR_CTRL)) begin
            rd_mux = {tc_flags[3], tr1, tc_flags[2], tr0, tc_flags[1], it1, tc_flags[0], it0};
        end else begin
            rd_mux = 8'h00;
            rd_map = 1'b0;
        end
    end

    // Data holds between reads so the core may sample late
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sfr_rdata_out <= 8'h00;
            sfr_hit_out   <= 1'b0;
        end else if (ce_in) begin
            sfr_hit_out <= sfr_req_in.rd & rd_map;
            if (sfr_req_in.rd) sfr_rdata_out <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    a_line_flag_set: assert property (ce_in |=>
        (line_flags & $past(line_fall)) == $past(line_fall))
        else $error("line flag missed its event");
    a_line_flag_clr: assert property (ce_in && wr_lf && line_fall == 8'h00 |=>
        line_flags == ($past(line_flags) & $past(wd)))
        else $error("line flag write-zero clear wrong");
    a_pwm_flag_set: assert property (ce_in |=>
        (pwm_flags & $past(pwm_event_in)) == $past(pwm_event_in))
        else $error("pwm flag missed its event");
    a_lvd_gate: assert property ((ce_in && !low_voltage_detect_irq_enable_in)[*2] |->
        ext_line_irq_out == 8'h00)
        else $error("line request without low-voltage enable");
    a_wake_no_ea: assert property (ce_in && pd && (|line_req)
        && !(wr_pc && wd[PWR_DOWN_BIT]) |=> wake_out && !power_down_out)
        else $error("enabled line failed to wake");
    a_pd_enter: assert property (ce_in && wr_pc && wd[PWR_DOWN_BIT] |=>
        power_down_out ##1 (power_down_out || !ce_in || $past(wr_pc) || $past(wake)))
        else $error("power-down not entered");
    a_idle_enter: assert property (ce_in && wr_pc && wd[PWR_SLEEP_BIT] |=> idle_out)
        else $error("idle not entered");
    a_double_rate: assert property (ce_in && wr_pc |=>
        uart1_double_rate_out == $past(wd[PWR_DOUBLE_BIT]))
        else $error("double rate bit not stored");
    a_t1_ack_clr: assert property (ce_in && tmr_evt_in.t1_ack && !tmr_evt_in.t1_ovf
        && !wr_tc |=> !tc_flags[3] ##1 (!timer1_irq_out || !$past(ce_in)))
        else $error("timer 1 flag not cleared by vector");
    a_t1_gating: assert property (ce_in && tr1 && timer1_pin_gating_in && !pin_lvl[9]
        |=> !timer1_count_en_out)
        else $error("timer 1 counted with gate pin low");
    a_ext0_level: assert property (ce_in && !it0 && !pin_lvl[8] |=> ext0_irq_out)
        else $error("level request missing for line 0");
    a_ext1_edge: assert property (ce_in && it1 && pin_fall[9] |=> tc_flags[1])
        else $error("line 1 edge not latched");

    c_wake_seen: cover property (ce_in && pd ##1 wake_out ##1 !power_down_out);
    c_set_on_clear: cover property (ce_in && wr_lf && (|line_fall));
    c_edge_irq: cover property (ce_in && it0 && pin_fall[8] ##1 tc_flags[0]);

endmodule : sic_sfr_irq_top

// [test/sic_cpu_model.sv]
`timescale 1ns/1ps
module sic_cpu_model
    import sic_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic [7:0] rdata_in,
    input  wire logic       hit_in,
    output sic_sfr_req_t    req_out,
    output sic_tmr_evt_t    evt_out
);
    initial begin
        req_out = '0;
        evt_out = '0;
    end

    // ------------------------------------------------------------
    // Bus cycles, launched on the falling edge
    // ------------------------------------------------------------
    // Idle bus shows inverted address and data, not the stale values
    // Flag clearing is a plain write of 0 to the flag bit
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_in);
        req_out = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(negedge clk_sys_in);
        req_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        @(negedge clk_sys_in);
        req_out = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(negedge clk_sys_in);
        req_out = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        d = rdata_in;
        h = hit_in;
    endtask : rd

    // Vectoring and overflow events last exactly one cycle
    task automatic evt(input sic_tmr_evt_t e);
        @(negedge clk_sys_in);
        evt_out = e;
        @(negedge clk_sys_in);
        evt_out = '0;
    endtask : evt
endmodule : sic_cpu_model

// [test/sic_sfr_irq_top_bench.sv]
`timescale 1ns/1ps
module sic_sfr_irq_top_bench
    import sic_pkg::*;
;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [7:0]   lines = 8'hff;
    logic         p0 = 1'b1;
    logic         p1 = 1'b1;
    logic [2:0]   pwm = 3'h0;
    logic         ge = 1'b0;
    logic         lvd = 1'b0;
    logic         gate = 1'b0;
    sic_sfr_req_t req;
    sic_tmr_evt_t evt;
    logic [7:0]   rdata, port0, sp, lirq;
    logic [15:0]  dptr;
    logic [2:0]   pirq;
    logic         hit, x0, x1, t0, t1, en0, en1, dbl, idle, pd, wk;
    int           bad_count = 0;
    int           checks = 0;
    int           cycles = 0;

    always #50 clk = ~clk;

    sic_sfr_irq_top dut_u (.clk_sys_in(clk), .rst_n_in(rst_n), .ce_in(1'b1),
        .sfr_req_in(req), .ext_line_pins_in(lines), .ext_line0_pin_in(p0),
        .ext_line1_pin_in(p1), .pwm_event_in(pwm), .tmr_evt_in(evt),
        .global_irq_enable_in(ge), .low_voltage_detect_irq_enable_in(lvd),
        .timer1_pin_gating_in(gate), .sfr_rdata_out(rdata), .sfr_hit_out(hit),
        .port0_data_out(port0), .stack_pointer_out(sp), .data_pointer_out(dptr),
        .ext_line_irq_out(lirq), .pwm_irq_out(pirq), .ext0_irq_out(x0),
        .ext1_irq_out(x1), .timer0_irq_out(t0), .timer1_irq_out(t1),
        .timer0_count_en_out(en0), .timer1_count_en_out(en1),
        .uart1_double_rate_out(dbl), .idle_out(idle), .power_down_out(pd),
        .wake_out(wk));

    sic_cpu_model cpu_u (.clk_sys_in(clk), .rdata_in(rdata), .hit_in(hit),
        .req_out(req), .evt_out(evt));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic eh);
        logic [7:0] d;
        logic       h;
        cpu_u.rd(a, d, h);
        chk("rdata", d, e);
        chk("hit", 8'(h), 8'(eh));
    endtask : rd_chk

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic give_verdict();
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 9; i++) begin
            rd_chk(8'h80 + 8'(i), (i == 1) ? RST_STACK : RST_ZERO, 1'b1);
        end
        rd_chk(8'h89, 8'h00, 1'b0);
        for (int i = 0; i < 4; i++) begin
            cpu_u.wr(8'h80 + 8'(i), 8'h3c + 8'(i));
        end
        chk("port0", port0, 8'h3c);
        chk("sp", sp, 8'h3d);
        chk("dptr", dptr[7:0], 8'h3e);
        chk("dptr_hi", dptr[15:8], 8'h3f);
        rd_chk(ADR_STACK, 8'h3d, 1'b1);
    endtask : t_regs

    task automatic t_power();
        cpu_u.wr(ADR_POWER_CTRL, 8'h8c);
        rd_chk(ADR_POWER_CTRL, 8'h8c, 1'b1);
        chk("double", 8'(dbl), 8'h01);
        chk("pd", 8'({pd, idle}), 8'h00);
        cpu_u.wr(ADR_POWER_CTRL, 8'h01);
        chk("double", 8'(dbl), 8'h00);
        chk("idle", 8'(idle), 8'h01);
        cpu_u.wr(ADR_POWER_CTRL, 8'hff);
        rd_chk(ADR_POWER_CTRL, 8'h8f, 1'b1);
        chk("pd", 8'(pd), 8'h01);
        cpu_u.wr(ADR_POWER_CTRL, 8'h00);
    endtask : t_power

    task automatic t_lines();
        lvd = 1'b1;
        cpu_u.wr(ADR_LINE_EN, 8'h81);
        lines = 8'h7e;
        cyc(8);
        rd_chk(ADR_LINE_FLAGS, 8'h81, 1'b1);
        chk("line_irq", lirq, 8'h81);
        lvd = 1'b0;
        cyc(2);
        chk("line_irq", lirq, 8'h00);
        lvd = 1'b1;
        cpu_u.wr(ADR_LINE_EN, 8'h01);
        cyc(1);
        chk("line_irq", lirq, 8'h01);
        cpu_u.wr(ADR_LINE_FLAGS, 8'hfe);
        rd_chk(ADR_LINE_FLAGS, 8'h80, 1'b1);
        cpu_u.wr(ADR_LINE_FLAGS, 8'h00);
        lines = 8'hff;
        // Power-down: a line without enable must not wake, an enabled one must
        cpu_u.wr(ADR_LINE_EN, 8'h10);
        cpu_u.wr(ADR_POWER_CTRL, 8'h02);
        lines = 8'hf7;
        cyc(10);
        chk("pd", 8'({wk, pd}), 8'h01);
        lines = 8'he7;
        cyc(6);
        chk("wake", 8'({wk, pd}), 8'h02);
        cyc(4);
        chk("wake", 8'({wk, pd}), 8'h00);
        // Same wake with the global enable set
        ge = 1'b1;
        cpu_u.wr(ADR_LINE_FLAGS, 8'h00);
        cpu_u.wr(ADR_POWER_CTRL, 8'h02);
        lines = 8'hff;
        cyc(6);
        chk("pd", 8'(pd), 8'h01);
        lines = 8'he7;
        cyc(6);
        chk("wake", 8'({wk, pd}), 8'h02);
        cpu_u.wr(ADR_LINE_FLAGS, 8'h00);
        lines = 8'hff;
    endtask : t_lines

    task automatic t_pwm();
        for (int i = 0; i < 3; i++) begin
            @(negedge clk) pwm = 3'(1 << i);
            @(negedge clk) pwm = 3'h0;
        end
        cyc(1);
        chk("pwm_irq", 8'(pirq), 8'h07);
        cpu_u.wr(ADR_PWM_FLAGS, 8'hfd);
        rd_chk(ADR_PWM_FLAGS, 8'h05, 1'b1);
        cpu_u.wr(ADR_PWM_FLAGS, 8'h00);
        cyc(1);
        chk("pwm_irq", 8'(pirq), 8'h00);
    endtask : t_pwm

    task automatic t_timer();
        cpu_u.evt('{t1_ovf: 1'b1, t0_ovf: 1'b1, default: 1'b0});
        cyc(1);
        chk("tmr_irq", 8'({t1, t0}), 8'h03);
        rd_chk(ADR_TMR_CTRL, 8'ha0, 1'b1);
        cpu_u.evt('{t1_ack: 1'b1, default: 1'b0});
        rd_chk(ADR_TMR_CTRL, 8'h20, 1'b1);
        cpu_u.evt('{t0_ack: 1'b1, default: 1'b0});
        rd_chk(ADR_TMR_CTRL, 8'h00, 1'b1);
        cpu_u.wr(ADR_TMR_CTRL, 8'h50);
        cyc(1);
        chk("count_en", 8'({en1, en0}), 8'h03);
        gate = 1'b1;
        p1 = 1'b0;
        cyc(6);
        chk("count_en1", 8'(en1), 8'h00);
        p1 = 1'b1;
        cyc(6);
        chk("count_en1", 8'(en1), 8'h01);
        gate = 1'b0;
        cpu_u.wr(ADR_TMR_CTRL, 8'h00);
        cyc(1);
        chk("count_en", 8'({en1, en0}), 8'h00);
    endtask : t_timer

    task automatic t_ext();
        cpu_u.wr(ADR_TMR_CTRL, 8'h05);
        p0 = 1'b0;
        p1 = 1'b0;
        cyc(8);
        rd_chk(ADR_TMR_CTRL, 8'h0f, 1'b1);
        chk("ext_irq", 8'({x1, x0}), 8'h03);
        cpu_u.evt('{x1_ack: 1'b1, x0_ack: 1'b1, default: 1'b0});
        rd_chk(ADR_TMR_CTRL, 8'h05, 1'b1);
        p0 = 1'b1;
        p1 = 1'b1;
        cpu_u.wr(ADR_TMR_CTRL, 8'h00);
        cyc(6);
        p0 = 1'b0;
        cyc(6);
        chk("ext_irq", 8'({x1, x0}), 8'h01);
        rd_chk(ADR_TMR_CTRL, 8'h00, 1'b1);
        p0 = 1'b1;
        p1 = 1'b0;
        cyc(6);
        chk("ext_irq", 8'({x1, x0}), 8'h02);
        p1 = 1'b1;
        cyc(6);
        chk("ext_irq", 8'({x1, x0}), 8'h00);
    endtask : t_ext

    // Ceiling far above the few hundred cycles the scenarios need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        cyc(10);
        rst_n = 1'b1;
        t_regs();
        t_power();
        t_lines();
        t_pwm();
        t_timer();
        t_ext();
        give_verdict();
    end
endmodule : sic_sfr_irq_top_bench
